// ---- core/sacoc_pkg.sv ----
// Constants and types of the shunt calibration and overcurrent block.
// Assumes one 200 MHz clock and a 16-bit register port.
package sacoc_pkg;

   // ==========================================
   // Register offsets
   localparam logic [7:0] ADDR_OCAL_HI = 8'hc4;
   localparam logic [7:0] ADDR_OCAL_LO = 8'hc5;
   localparam logic [7:0] ADDR_GCAL = 8'hc6;
   localparam logic [7:0] ADDR_OC_CFG = 8'hc7;
   localparam logic [7:0] ADDR_HI_TH = 8'hc8;
   localparam logic [7:0] ADDR_LO_TH = 8'hc9;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'hd0;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'hd1;
   localparam logic [7:0] ADDR_OC_STATE = 8'hd2;
   localparam logic [7:0] ADDR_FAST_VAL = 8'hd3;

   // ==========================================
   // Reset values
   localparam logic [15:0] RST_OCAL_HI = 16'h0000;
   localparam logic [7:0] RST_OCAL_LO = 8'h00;
   localparam logic [15:0] RST_GCAL = 16'h0000;
   localparam logic [15:0] RST_HI_TH = 16'h7fff;
   localparam logic [15:0] RST_LO_TH = 16'h8000;

   // ==========================================
   // Field positions of the overcurrent config and of the offset low register
   localparam int CFG_EN_BIT = 15;
   localparam int CFG_POL_BIT = 14;
   localparam int CFG_RSV_BIT = 13;
   localparam int CFG_NUM_HI = 12;
   localparam int CFG_NUM_LO = 8;
   localparam int OCAL_LO_HI = 15;
   localparam int OCAL_LO_LO = 8;

   // ==========================================
   // Fast filter
   localparam int FAST_OSR = 64;
   localparam int FAST_ORDER = 3;
   localparam int FAST_ACC_W = 20;
   localparam int FAST_SHIFT = 3;

   // ==========================================
   // Carriers
   typedef struct packed {
      logic [23:0] offset_cal_word;
      logic [15:0] gain_cal_word;
   } sacoc_cal_t;

   typedef struct packed {
      logic overcurrent_enable;
      logic fault_pin_polarity;
      logic rsv13;
      logic [4:0] deglitch_count_sel;
   } sacoc_cfg_t;

   typedef struct packed {
      logic high_threshold_event;
      logic low_threshold_event;
   } sacoc_evt_t;

endpackage : sacoc_pkg

// ---- core/sacoc_top.sv ----
// Calibration and overcurrent configuration of the second shunt channel.
// Assumes a same-clock register master and a raw modulator bitstream pin.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps

// How it works
// [R1] Offset word bits 23:8 live in offset_cal_high bits 15:0, read/write.
// [R2] Offset bits 7:0 live in offset_cal_low 15:8; its bits 7:0 read zero.
// [R3] The 24-bit offset word is handed on as two's complement.
// [R4] The 16-bit gain word is a two's complement correction, step 2^-16.
// [R5] Enable bit 15 with the channel enabled runs filter and comparator.
// [R6] Start and stop commands never halt or restart the fast filter.
// [R7] Polarity bit 14 picks a low (0) or high (1) pin level on a fault.
// [R8] The fault is active while either threshold event is active.
// [R9] The fault reaches the shared pin only when selected, per format.
// [R10] Field 12:8 sets how many conversions must lie beyond a threshold.
// [R11] The fast path is a third-order sinc with a fixed ratio of 64.
// [R12] A conversion back inside the threshold restarts the count.
// [R13] Code 0 needs one conversion, rising to 128 at code 31.
// [R14] A value above the signed high threshold raises the high event.
// [R15] A value below the signed low threshold raises the low event.
// [R16] Comparisons are signed, with separate counts for high and low.
module sacoc_top #(
   parameter int DATA_W = 16,
   parameter int ADDR_W = 8,
   parameter int CNT_W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // Channel context
   input wire logic channel_enable,
   input wire logic channel_start_cmd,
   input wire logic channel_stop_cmd,
   input wire logic mod_bit,
   input wire logic mod_strobe,
   // Shared pin control
   input wire logic shared_pin_source_sel,
   input wire logic shared_pin_format_sel,
   input wire logic shared_pin_gpio_level,
   // Results
   output sacoc_pkg::sacoc_cal_t cal_out,
   output sacoc_pkg::sacoc_evt_t evt_out,
   output logic overcurrent_fault_pin_o,
   output logic overcurrent_fault_pin_oe_n,
   output logic irq
);

   // ==========================================
   // Deglitch code to required count
   function automatic logic [CNT_W-1:0] need_cnt(input logic [4:0] c);
      logic [7:0] n;
      n = 8'h01;
      case (c)
         5'h00: n = 8'h01;
         5'h01: n = 8'h02;
         5'h02: n = 8'h03;
         5'h03: n = 8'h04;
         5'h04: n = 8'h05;
         5'h05: n = 8'h06;
         5'h06: n = 8'h07;
         5'h07: n = 8'h08;
         5'h08: n = 8'h09;
         5'h09: n = 8'h0a;
         5'h0a: n = 8'h0c;
         5'h0b: n = 8'h0e;
         5'h0c: n = 8'h10;
         5'h0d: n = 8'h12;
         5'h0e: n = 8'h14;
         5'h0f: n = 8'h16;
         5'h10: n = 8'h18;
         5'h11: n = 8'h1a;
         5'h12: n = 8'h1c;
         5'h13: n = 8'h20;
         5'h14: n = 8'h28;
         5'h15: n = 8'h30;
         5'h16: n = 8'h38;
         5'h17: n = 8'h40;
         5'h18: n = 8'h48;
         5'h19: n = 8'h50;
         5'h1a: n = 8'h58;
         5'h1b: n = 8'h60;
         5'h1c: n = 8'h68;
         5'h1d: n = 8'h70;
         5'h1e: n = 8'h78;
         default: n = 8'h80;
      endcase
      need_cnt = CNT_W'(n);
   endfunction : need_cnt

   // ==========================================
   // Registers
   logic [15:0] ocal_hi_r;
   logic [7:0] ocal_lo_r;
   logic [15:0] gcal_r;
   sacoc_pkg::sacoc_cfg_t cfg_r;
   logic [15:0] hi_th_r;
   logic [15:0] lo_th_r;
   logic [1:0] stat_r;
   logic [1:0] stat_nxt;
   logic [1:0] mask_r;
   logic [DATA_W-1:0] rdata_nxt;

   // ==========================================
   // Address decode
   wire sel_ocal_hi = reg_addr == ADDR_W'(sacoc_pkg::ADDR_OCAL_HI);
   wire sel_ocal_lo = reg_addr == ADDR_W'(sacoc_pkg::ADDR_OCAL_LO);
   wire sel_gcal = reg_addr == ADDR_W'(sacoc_pkg::ADDR_GCAL);
   wire sel_cfg = reg_addr == ADDR_W'(sacoc_pkg::ADDR_OC_CFG);
   wire sel_hi_th = reg_addr == ADDR_W'(sacoc_pkg::ADDR_HI_TH);
   wire sel_lo_th = reg_addr == ADDR_W'(sacoc_pkg::ADDR_LO_TH);
   wire sel_stat = reg_addr == ADDR_W'(sacoc_pkg::ADDR_IRQ_STAT);
   wire sel_mask = reg_addr == ADDR_W'(sacoc_pkg::ADDR_IRQ_MASK);
   wire sel_state = reg_addr == ADDR_W'(sacoc_pkg::ADDR_OC_STATE);
   wire sel_fval = reg_addr == ADDR_W'(sacoc_pkg::ADDR_FAST_VAL);

   // ==========================================
   // Register writes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ocal_hi_r <= sacoc_pkg::RST_OCAL_HI;
         ocal_lo_r <= sacoc_pkg::RST_OCAL_LO;
         gcal_r <= sacoc_pkg::RST_GCAL;
         cfg_r <= '0;
         hi_th_r <= sacoc_pkg::RST_HI_TH;
         lo_th_r <= sacoc_pkg::RST_LO_TH;
         mask_r <= 2'h0;
      end else if (clk_en && reg_wr) begin
         if (sel_ocal_hi) begin
            ocal_hi_r <= reg_wdata[15:0]; // [R1]
         end else if (sel_ocal_lo) begin
            ocal_lo_r <= reg_wdata[sacoc_pkg::OCAL_LO_HI:
                                   sacoc_pkg::OCAL_LO_LO]; // [R2]
         end else if (sel_gcal) begin
            gcal_r <= reg_wdata[15:0];
         end else if (sel_cfg) begin
            cfg_r <= reg_wdata[sacoc_pkg::CFG_EN_BIT:
                               sacoc_pkg::CFG_NUM_LO];
         end else if (sel_hi_th) begin
            hi_th_r <= reg_wdata[15:0];
         end else if (sel_lo_th) begin
            lo_th_r <= reg_wdata[15:0];
         end else if (sel_mask) begin
            mask_r <= reg_wdata[1:0];
         end
      end
   end

   // ==========================================
   // Modulator input synchroniser
   logic mod_s1_r;
   logic mod_s2_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mod_s1_r <= 1'b0;
         mod_s2_r <= 1'b0;
      end else if (clk_en) begin
         mod_s1_r <= mod_bit;
         mod_s2_r <= mod_s1_r;
      end
   end

   // ==========================================
   // Fast sinc3 filter, ratio 64
   localparam int AW = sacoc_pkg::FAST_ACC_W;
   localparam int N = sacoc_pkg::FAST_ORDER;
   // Start and stop are deliberately not used here
   wire run = cfg_r.overcurrent_enable & channel_enable; // [R5] [R6]
   wire samp = run & mod_strobe;
   logic [AW-1:0] integ_r [N];
   logic [AW-1:0] comb_r [N];
   logic [AW-1:0] stage [N+1];
   logic [5:0] dec_r;
   logic fast_vld_r;
   logic signed [15:0] fast_r;
   wire dec_end = samp && dec_r == 6'(sacoc_pkg::FAST_OSR - 1);
   wire [AW-1:0] x_in = mod_s2_r ? AW'(1) : {AW{1'b1}};

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_stage
         wire [AW-1:0] in_i = (g == 0) ? x_in : integ_r[g > 0 ? g-1 : 0];
         always_ff @(posedge clk) begin
            if (sys_rst || (clk_en && !run)) begin
               integ_r[g] <= '0;
               comb_r[g] <= '0;
            end else if (clk_en) begin
               if (samp) integ_r[g] <= integ_r[g] + in_i; // [R11]
               if (dec_end) comb_r[g] <= stage[g];
            end
         end
         assign stage[g+1] = stage[g] - comb_r[g];
      end
   endgenerate
   assign stage[0] = integ_r[N-1];

   // Scale the full sum down to 16 bits with saturation
   wire signed [AW-1:0] full = stage[N];
   wire signed [AW-1:0] shr = full >>> sacoc_pkg::FAST_SHIFT;
   wire ovf = shr > AW'(32767);
   wire [15:0] scaled = ovf ? 16'h7fff : shr[15:0];

   always_ff @(posedge clk) begin
      if (sys_rst || (clk_en && !run)) begin
         dec_r <= 6'h00;
         fast_vld_r <= 1'b0;
         fast_r <= 16'sh0000;
      end else if (clk_en) begin
         if (samp) dec_r <= dec_r + 6'h01;
         fast_vld_r <= dec_end;
         if (dec_end) fast_r <= scaled;
      end
   end

   // ==========================================
   // Comparator and deglitch
   wire signed [15:0] hi_th = hi_th_r;
   wire signed [15:0] lo_th = lo_th_r;
   wire over_hi = fast_r > hi_th; // [R14] [R16]
   wire under_lo = fast_r < lo_th; // [R15] [R16]
   wire [CNT_W-1:0] need = need_cnt(cfg_r.deglitch_count_sel); // [R10] [R13]
   logic [CNT_W-1:0] hi_cnt_r;
   logic [CNT_W-1:0] lo_cnt_r;
   sacoc_pkg::sacoc_evt_t evt_r;
   wire [CNT_W-1:0] hi_cnt_inc = hi_cnt_r + CNT_W'(1);
   wire [CNT_W-1:0] lo_cnt_inc = lo_cnt_r + CNT_W'(1);

   always_ff @(posedge clk) begin
      if (sys_rst || (clk_en && !run)) begin
         hi_cnt_r <= '0;
         lo_cnt_r <= '0;
         evt_r <= '0;
      end else if (clk_en && fast_vld_r) begin
         if (!over_hi) begin
            hi_cnt_r <= '0; // [R12]
            evt_r.high_threshold_event <= 1'b0;
         end else if (hi_cnt_inc >= need) begin
            hi_cnt_r <= need;
            evt_r.high_threshold_event <= 1'b1; // [R10]
         end else begin
            hi_cnt_r <= hi_cnt_inc;
         end
         if (!under_lo) begin
            lo_cnt_r <= '0; // [R12]
            evt_r.low_threshold_event <= 1'b0;
         end else if (lo_cnt_inc >= need) begin
            lo_cnt_r <= need;
            evt_r.low_threshold_event <= 1'b1; // [R10]
         end else begin
            lo_cnt_r <= lo_cnt_inc;
         end
      end
   end

   // ==========================================
   // Fault and shared pin
   wire fault = evt_r.high_threshold_event | evt_r.low_threshold_event; // [R8]
   wire fault_lvl = cfg_r.fault_pin_polarity ? fault : ~fault; // [R7]
   wire pin_lvl = shared_pin_source_sel ? fault_lvl
                                        : shared_pin_gpio_level; // [R9]
   // Format 1 is open drain: drive only a low level
   wire pin_drv = ~shared_pin_format_sel | ~pin_lvl; // [R9]
   logic pin_o_r;
   logic pin_oe_n_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_o_r <= 1'b0;
         pin_oe_n_r <= 1'b1;
      end else if (clk_en) begin
         pin_o_r <= pin_lvl;
         pin_oe_n_r <= ~pin_drv;
      end
   end

   // ==========================================
   // Interrupt status, write one to clear, set wins
   logic [1:0] evt_d_r;
   wire [1:0] evt_now = {evt_r.low_threshold_event,
                         evt_r.high_threshold_event};
   wire [1:0] evt_rise = evt_now & ~evt_d_r;
   wire [1:0] w1c = (reg_wr && sel_stat) ? reg_wdata[1:0] : 2'h0;
   assign stat_nxt = (stat_r & ~w1c) | evt_rise;
   logic irq_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         evt_d_r <= 2'h0;
         stat_r <= 2'h0;
         irq_r <= 1'b0;
      end else if (clk_en) begin
         evt_d_r <= evt_now;
         stat_r <= stat_nxt;
         irq_r <= |(stat_nxt & mask_r);
      end
   end

   // ==========================================
   // Read data
   wire [15:0] cfg_rd = {cfg_r, 8'h00};
   wire [15:0] state_rd = {12'h000, run, fault, evt_now};
   always_comb begin
      rdata_nxt = '0;
      if (sel_ocal_hi) begin
         rdata_nxt = DATA_W'(ocal_hi_r); // [R1]
      end else if (sel_ocal_lo) begin
         rdata_nxt = DATA_W'({ocal_lo_r, 8'h00}); // [R2]
      end else if (sel_gcal) begin
         rdata_nxt = DATA_W'(gcal_r);
      end else if (sel_cfg) begin
         rdata_nxt = DATA_W'(cfg_rd);
      end else if (sel_hi_th) begin
         rdata_nxt = DATA_W'(hi_th_r);
      end else if (sel_lo_th) begin
         rdata_nxt = DATA_W'(lo_th_r);
      end else if (sel_stat) begin
         rdata_nxt = DATA_W'(stat_r);
      end else if (sel_mask) begin
         rdata_nxt = DATA_W'(mask_r);
      end else if (sel_state) begin
         rdata_nxt = DATA_W'(state_rd);
      end else if (sel_fval) begin
         rdata_nxt = DATA_W'(fast_r);
      end
   end

   logic [DATA_W-1:0] rdata_r;
   sacoc_pkg::sacoc_cal_t cal_r;
   sacoc_pkg::sacoc_evt_t evt_o_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_r <= '0;
         cal_r <= '0;
         evt_o_r <= '0;
      end else if (clk_en) begin
         rdata_r <= reg_rd ? rdata_nxt : '0;
         cal_r.offset_cal_word <= {ocal_hi_r, ocal_lo_r}; // [R3]
         cal_r.gain_cal_word <= gcal_r; // [R4]
         evt_o_r <= evt_r;
      end
   end

   // ==========================================
   // Outputs
   assign reg_rdata = rdata_r;
   assign cal_out = cal_r;
   assign evt_out = evt_o_r;
   assign overcurrent_fault_pin_o = pin_o_r;
   assign overcurrent_fault_pin_oe_n = pin_oe_n_r;
   assign irq = irq_r;

endmodule : sacoc_top

// ---- bench/sacoc_top_asserts.sv ----
// Port checker of the shunt calibration and overcurrent block.
// Assumes one clock and the default widths of the top module.
`timescale 1ns/10ps
module sacoc_top_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // Channel and pin
   input wire logic channel_enable,
   input wire logic shared_pin_source_sel,
   input wire logic shared_pin_format_sel,
   input wire logic shared_pin_gpio_level,
   input wire sacoc_pkg::sacoc_cal_t cal_out,
   input wire sacoc_pkg::sacoc_evt_t evt_out,
   input wire logic overcurrent_fault_pin_o,
   input wire logic overcurrent_fault_pin_oe_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ==========================================
   // Register side
   wire wr_hi = reg_wr && reg_addr == 8'hc4;
   wire wr_lo = reg_wr && reg_addr == 8'hc5;
   wire wr_gn = reg_wr && reg_addr == 8'hc6;
   wire rd_rsv = reg_rd && (reg_addr == 8'hc5 || reg_addr == 8'hc7);
   a_rd_idle: assert property (!reg_rd && clk_en |=> reg_rdata == 16'h0000)
      else $error("read data not idle");
   a_rsv_zero: assert property (rd_rsv |=> reg_rdata[7:0] == 8'h00)
      else $error("reserved bits not zero");
   a_ocal_high: assert property (wr_hi |-> ##2
      cal_out.offset_cal_word[23:8] == $past(reg_wdata, 2))
      else $error("offset high word wrong");
   a_ocal_low: assert property (wr_lo |-> ##2
      cal_out.offset_cal_word[7:0] == $past(reg_wdata[15:8], 2))
      else $error("offset low byte wrong");
   a_gain_word: assert property (wr_gn |-> ##2
      cal_out.gain_cal_word == $past(reg_wdata, 2))
      else $error("gain word wrong");
   // ==========================================
   // Pin and events
   a_pin_gpio: assert property (!shared_pin_source_sel |=>
      overcurrent_fault_pin_o == $past(shared_pin_gpio_level))
      else $error("pin not following gpio level");
   a_open_drain: assert property (!$past(sys_rst) |->
      overcurrent_fault_pin_oe_n ==
      ($past(shared_pin_format_sel) & overcurrent_fault_pin_o))
      else $error("pin enable wrong");
   a_evt_off: assert property (!channel_enable [*3] |->
      evt_out == 2'b00)
      else $error("event while channel off");
   a_evt_run: assert property ($rose(|evt_out) |->
      $past(channel_enable, 2))
      else $error("event without channel");
   c_high: cover property ($rose(evt_out.high_threshold_event));
   c_low: cover property ($rose(evt_out.low_threshold_event));
   c_release: cover property ($rose(overcurrent_fault_pin_oe_n));
endmodule : sacoc_top_asserts

bind sacoc_top sacoc_top_asserts u_chk (.clk, .sys_rst, .clk_en, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .channel_enable,
   .shared_pin_source_sel, .shared_pin_format_sel, .shared_pin_gpio_level,
   .cal_out, .evt_out, .overcurrent_fault_pin_o, .overcurrent_fault_pin_oe_n);

// ---- bench/sacoc_host.sv ----
// Host model that drives the register port.
// Assumes read data stand in the cycle after the read strobe.
`timescale 1ns/10ps
module sacoc_host (
   // Clock
   input wire logic clk,
   // Register port
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [15:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask : rd
endmodule : sacoc_host

// ---- bench/shunt_adc_cal_overcurrent_cfg_tb_top.sv ----
// Self-checking bench of the shunt calibration and overcurrent block.
// Assumes the host model drives the register port.
`timescale 1ns/10ps
module shunt_adc_cal_overcurrent_cfg_tb_top;
   // ==========================================
   // Signals
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic ch_en = 1'b0, st = 1'b0, sp = 1'b0, mbit = 1'b0, mstb = 1'b0;
   logic src = 1'b0, fmt = 1'b0, gpio = 1'b0;
   logic [7:0] addr, a;
   logic [15:0] wdata, rdata, v, d;
   logic [15:0] m [3] = '{16'h0000, 16'h0000, 16'h0000};
   logic [15:0] cor [4] = '{16'h7fff, 16'h8000, 16'hffff, 16'h00ff};
   logic [15:0] rst_v [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h7fff, 16'h8000};
   logic [4:0] codes [6] = '{5'h00, 5'h09, 5'h0a, 5'h12, 5'h13, 5'h1f};
   logic wr, rd, pin_o, pin_oe_n, irq;
   sacoc_pkg::sacoc_cal_t cal;
   sacoc_pkg::sacoc_evt_t evt;
   int miscompares = 0;
   int n_compared = 0;
   int n;
   initial begin
      forever #2.5 clk = ~clk;
   end
   sacoc_top dut (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
      .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(rdata), .channel_enable(ch_en), .channel_start_cmd(st),
      .channel_stop_cmd(sp), .mod_bit(mbit), .mod_strobe(mstb),
      .shared_pin_source_sel(src), .shared_pin_format_sel(fmt),
      .shared_pin_gpio_level(gpio), .cal_out(cal), .evt_out(evt),
      .overcurrent_fault_pin_o(pin_o),
      .overcurrent_fault_pin_oe_n(pin_oe_n), .irq(irq));
   sacoc_host host (.clk(clk), .reg_addr(addr), .reg_wdata(wdata),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
   // ==========================================
   // Helpers
   task automatic check(input string nm, input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic rchk(input logic [7:0] ra, input logic [15:0] exp);
      host.rd(ra, v);
      check($sformatf("reg %h", ra), v, exp);
   endtask : rchk
   task automatic wait_evt(input int lim);
      for (int k = 0; k < lim && evt === 2'b00; k++) @(posedge clk);
   endtask : wait_evt
   function automatic logic [15:0] rb(input logic [7:0] ra, logic [15:0] x);
      return (ra == 8'hc5) ? {x[15:8], 8'h00} : x;
   endfunction : rb
   function automatic int need(input logic [4:0] c);
      if (c < 5'h0a) return int'(c) + 1;
      if (c < 5'h13) return 2 * int'(c) - 8;
      return 8 * int'(c) - 120;
   endfunction : need
   task automatic print_verdict;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict
   initial begin
      #300000;
      miscompares++;
      print_verdict();
   end
   // ==========================================
   // Tests
   initial begin
      n = $urandom(70);
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rchk(8'hc4 + 8'(i), rst_v[i]);
      end
      rchk(8'h55, 16'h0000);
      for (int i = 0; i < 40; i++) begin
         n = $urandom_range(0, 2);
         d = (i < 4) ? cor[i % 4] : 16'($urandom);
         a = 8'hc4 + 8'(n);
         host.wr(a, d);
         m[n] = rb(a, d);
         rchk(a, m[n]);
      end
      check("ocal hi", cal.offset_cal_word[23:8], m[0]);
      check("ocal lo", {cal.offset_cal_word[7:0], 8'h00}, m[1]);
      check("gcal", cal.gain_cal_word, m[2]);
      src <= 1'b1;
      host.wr(8'hc8, 16'h7ffe);
      host.wr(8'hd1, 16'h0001);
      host.wr(8'hc7, 16'h8000);
      ch_en <= 1'b1;
      mbit <= 1'b1;
      mstb <= 1'b1;
      wait_evt(400);
      check("high evt", {14'h0000, evt}, 16'h0002);
      repeat (300) begin
         @(posedge clk);
         st <= 1'($urandom);
         sp <= 1'($urandom);
      end
      check("evt run", {14'h0000, evt}, 16'h0002);
      rchk(8'hd3, 16'h7fff);
      rchk(8'hd2, 16'h000d);
      check("pin low", {14'h0000, pin_oe_n, pin_o}, 16'h0000);
      check("irq", {15'h0000, irq}, 16'h0001);
      host.wr(8'hd1, 16'h0000);
      @(posedge clk);
      check("irq mask", {15'h0000, irq}, 16'h0000);
      host.wr(8'hd1, 16'h0001);
      @(posedge clk);
      check("irq unmask", {15'h0000, irq}, 16'h0001);
      host.wr(8'hd0, 16'h0001);
      check("irq clear", {15'h0000, irq}, 16'h0000);
      host.wr(8'hc7, 16'hc000);
      fmt <= 1'b1;
      repeat (2) @(posedge clk);
      check("pin high", {14'h0000, pin_oe_n, pin_o}, 16'h0003);
      src <= 1'b0;
      gpio <= 1'b0;
      repeat (2) @(posedge clk);
      check("pin gpio", {14'h0000, pin_oe_n, pin_o}, 16'h0000);
      ch_en <= 1'b0;
      repeat (3) @(posedge clk);
      check("evt off", {14'h0000, evt}, 16'h0000);
      mbit <= 1'b0;
      host.wr(8'hc8, 16'h7fff);
      host.wr(8'hc9, 16'h8001);
      foreach (codes[i]) begin
         ch_en <= 1'b0;
         host.wr(8'hc7, {3'b100, codes[i], 8'h00});
         ch_en <= 1'b1;
         // Two settling conversions, then need() beyond, then two stages
         repeat ((need(codes[i]) + 2) * 64 + 2) @(posedge clk);
         check("early", {14'h0000, evt}, 16'h0000);
         @(posedge clk);
         check("late", {14'h0000, evt}, 16'h0001);
      end
      rchk(8'hc7, 16'h9f00);
      rchk(8'hd3, 16'h8000);
      // One conversion back inside restarts a count of four
      ch_en <= 1'b0;
      host.wr(8'hc7, 16'h8300);
      ch_en <= 1'b1;
      repeat (200) @(posedge clk);
      host.wr(8'hc9, 16'h8000);
      repeat (77) @(posedge clk);
      host.wr(8'hc9, 16'h8001);
      repeat (231) @(posedge clk);
      check("restart early", {14'h0000, evt}, 16'h0000);
      @(posedge clk);
      check("restart late", {14'h0000, evt}, 16'h0001);
      print_verdict();
   end
endmodule : shunt_adc_cal_overcurrent_cfg_tb_top
